// file: rtl/phase_down_counter.sv
`timescale 1ns/100ps
module phase_down_counter
  import pll_pkg::*;
#(
  parameter int WIDTH = MOD_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic clear,
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] count,
  output logic terminal
);
  logic [WIDTH-1:0] count_q;
  logic terminal_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= '0;
    end else if (clear) begin
      count_q <= '0;
    end else if (tick) begin
      if (count_q == '0) begin
        count_q <= load_value;
      end else begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      terminal_q <= 1'b0;
    end else begin
      terminal_q <= tick && !clear && (count_q == '0);
    end
  end

  assign count = count_q;
  assign terminal = terminal_q;

  a_reload_modulus: assert property (@(posedge clk) disable iff (!arst_n)
    tick && !clear && count_q == '0 |=> count_q == $past(load_value))
    else $error("Counter did not reload its modulus");
endmodule : phase_down_counter

// file: rtl/pixel_clock_pll_phase_comparator.sv
`timescale 1ns/100ps
module pixel_clock_pll_phase_comparator
  import pll_pkg::*;
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic HIGH_FREQ_CLOCK_IN,
  input wire logic VCO_FEEDBACK_CLOCK_IN,
  input wire logic IO_CLOCK_INPUT,
  input wire logic SOUND_CLOCK_IN,
  output logic VCO_FEEDBACK_INVERTED_OUT,
  output logic PHASE_CORRECTION_OUT_O,
  output logic PHASE_CORRECTION_OUT_OE,
  output logic PIXEL_CLOCK_EN,
  output logic SOUND_CLOCK_EN
);
  localparam int PIN_N = 4;
  localparam int PIN_DIRECT = 0;
  localparam int PIN_VCO = 1;
  localparam int PIN_IO = 2;
  localparam int PIN_SOUND = 3;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_rise;
  logic [7:0] control_q;
  logic [15:0] synth_q;
  logic ref_tick;
  logic pixel_tick;
  logic sound_tick;
  logic sound_half_q;
  logic sound_en_q;
  logic [MOD_W-1:0] ref_count;
  logic [MOD_W-1:0] vco_count;
  logic ref_tc;
  logic vco_tc;
  detector_state_t det_q;
  logic corr_o_q;
  logic corr_oe_q;
  logic force_high;
  logic force_low;
  logic clear_r;
  logic clear_v;

  assign pin_raw = {SOUND_CLOCK_IN, IO_CLOCK_INPUT, VCO_FEEDBACK_CLOCK_IN, HIGH_FREQ_CLOCK_IN};

  // Pins are sampled; a level counts once stages two and three agree
  for (genvar g = 0; g < PIN_N; g++) begin : g_pin
    logic [SYNC_STAGES-1:0] sync_q;
    logic level_q;
    always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
        sync_q <= '0;
      end else begin
        sync_q <= {sync_q[SYNC_STAGES-2:0], pin_raw[g]};
      end
    end
    always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
        level_q <= 1'b0;
      end else if (sync_q[1] == sync_q[2]) begin
        level_q <= sync_q[2];
      end
    end
    assign pin_rise[g] = (sync_q[1] == sync_q[2]) && sync_q[2] && !level_q;
  end

  // The I/O clock serves directly as the internal reference
  assign ref_tick = pin_rise[PIN_IO];

  // Inverted pin copy for the external bias resistor; not sampled, as it must follow the pin
  assign VCO_FEEDBACK_INVERTED_OUT = ~VCO_FEEDBACK_CLOCK_IN;

  // Register bus: write channel
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write;

  assign AWREADY = !aw_have_q && !bvalid_q;
  assign WREADY = !w_have_q && !bvalid_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (AWVALID && AWREADY) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= AWADDR;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (WVALID && WREADY) begin
      w_have_q <= 1'b1;
      w_data_q <= WDATA;
      w_strb_q <= WSTRB;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      if (aw_addr_q == CONTROL_ADDR || aw_addr_q == SYNTH_ADDR || aw_addr_q == STATUS_ADDR) begin
        bresp_q <= RESP_OKAY;
      end else begin
        bresp_q <= RESP_SLVERR;
      end
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      control_q <= CONTROL_RESET;
    end else if (do_write && aw_addr_q == CONTROL_ADDR && w_strb_q[0]) begin
      control_q <= w_data_q[7:0];
    end
  end

  // Moduli and test bits change together per byte lane
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      synth_q <= SYNTH_RESET;
    end else if (do_write && aw_addr_q == SYNTH_ADDR) begin
      if (w_strb_q[0]) begin
        synth_q[7:0] <= w_data_q[7:0];
      end
      if (w_strb_q[1]) begin
        synth_q[15:8] <= w_data_q[15:8];
      end
    end
  end

  // Register bus: read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign ARREADY = !rvalid_q;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      if (ARADDR == CONTROL_ADDR) begin
        rdata_q <= {24'h000000, control_q};
      end else if (ARADDR == SYNTH_ADDR) begin
        rdata_q <= {16'h0000, synth_q};
      end else if (ARADDR == STATUS_ADDR) begin
        rdata_q <= {12'h000, 2'b00, vco_count, 2'b00, ref_count, corr_oe_q, corr_o_q, det_q};
      end else begin
        rdata_q <= '0;
        rresp_q <= RESP_SLVERR;
      end
    end else if (RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

  // Pixel clock path
  always_comb begin
    case (control_q[SRC_LSB +: SRC_W])
      SRC_DIRECT: pixel_tick = pin_rise[PIN_DIRECT];
      SRC_VCO: pixel_tick = pin_rise[PIN_VCO];
      default: pixel_tick = ref_tick;
    endcase
  end

  pixel_prescaler u_prescaler (
    .clk(CLOCK),
    .arst_n(ARST_N),
    .tick(pixel_tick),
    .ratio(control_q[PRESCALE_LSB +: PRESCALE_W]),
    .pulse(PIXEL_CLOCK_EN)
  );

  // Sound clock path with the fixed halving stage
  assign sound_tick = control_q[SOUND_SEL_BIT] ? pin_rise[PIN_SOUND] : ref_tick;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sound_half_q <= 1'b0;
      sound_en_q <= 1'b0;
    end else begin
      if (sound_tick) begin
        sound_half_q <= !sound_half_q;
      end
      sound_en_q <= sound_tick && sound_half_q;
    end
  end

  assign SOUND_CLOCK_EN = sound_en_q;

  // Phase comparator
  assign force_high = synth_q[FORCE_HIGH_BIT];
  assign force_low = synth_q[FORCE_LOW_BIT];
  assign clear_r = synth_q[CLEAR_R_BIT];
  assign clear_v = synth_q[CLEAR_V_BIT];

  phase_down_counter #(.WIDTH(MOD_W)) u_ref_counter (
    .clk(CLOCK),
    .arst_n(ARST_N),
    .tick(ref_tick),
    .clear(clear_r),
    .load_value(synth_q[RMOD_LSB +: MOD_W]),
    .count(ref_count),
    .terminal(ref_tc)
  );

  phase_down_counter #(.WIDTH(MOD_W)) u_vco_counter (
    .clk(CLOCK),
    .arst_n(ARST_N),
    .tick(pin_rise[PIN_VCO]),
    .clear(clear_v),
    .load_value(synth_q[VMOD_LSB +: MOD_W]),
    .count(vco_count),
    .terminal(vco_tc)
  );

  // Expiries in the same cycle leave an idle detector idle, which is the lock point
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      det_q <= DET_IDLE;
    end else begin
      case (det_q)
        DET_IDLE: begin
          if (ref_tc && !vco_tc) begin
            det_q <= DET_UP;
          end else if (vco_tc && !ref_tc) begin
            det_q <= DET_DOWN;
          end
        end
        DET_UP: begin
          if (vco_tc && !ref_tc) begin
            det_q <= DET_IDLE;
          end
        end
        DET_DOWN: begin
          if (ref_tc && !vco_tc) begin
            det_q <= DET_IDLE;
          end
        end
        default: det_q <= DET_IDLE;
      endcase
    end
  end

  // Forced low wins over forced high so a bad write never runs the VCO away
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      corr_o_q <= 1'b0;
      corr_oe_q <= 1'b0;
    end else if (force_low) begin
      corr_o_q <= 1'b0;
      corr_oe_q <= 1'b1;
    end else if (force_high) begin
      corr_o_q <= 1'b1;
      corr_oe_q <= 1'b1;
    end else begin
      corr_o_q <= (det_q == DET_UP);
      corr_oe_q <= (det_q != DET_IDLE);
    end
  end

  assign PHASE_CORRECTION_OUT_O = corr_o_q;
  assign PHASE_CORRECTION_OUT_OE = corr_oe_q;

  a_force_low_drive: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    force_low |=> PHASE_CORRECTION_OUT_OE && !PHASE_CORRECTION_OUT_O)
    else $error("Forced low not driven low");

  a_force_high_drive: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    force_high && !force_low |=> PHASE_CORRECTION_OUT_OE && PHASE_CORRECTION_OUT_O)
    else $error("Forced high not driven high");

  a_idle_floats: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !force_high && !force_low && det_q == DET_IDLE |=> !PHASE_CORRECTION_OUT_OE)
    else $error("Correction driven while detector idle");

  a_up_drives_high: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !force_high && !force_low && det_q == DET_UP |=> PHASE_CORRECTION_OUT_OE && PHASE_CORRECTION_OUT_O)
    else $error("Speed-up request not driven high");

  a_down_drives_low: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !force_high && !force_low && det_q == DET_DOWN |=> PHASE_CORRECTION_OUT_OE && !PHASE_CORRECTION_OUT_O)
    else $error("Slow-down request not driven low");

  a_ref_clear_hold: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    clear_r ##1 clear_r |-> ref_count == '0 && !ref_tc)
    else $error("Reference counter not held cleared");

  a_vco_clear_hold: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    clear_v ##1 clear_v |-> vco_count == '0 && !vco_tc)
    else $error("VCO counter not held cleared");

  a_ref_first_up: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    det_q == DET_IDLE && ref_tc && !vco_tc |=> det_q == DET_UP)
    else $error("Reference expiry did not request speed-up");

  a_vco_first_down: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    det_q == DET_IDLE && vco_tc && !ref_tc |=> det_q == DET_DOWN)
    else $error("VCO expiry did not request slow-down");

  a_vco_source_tick: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    control_q[SRC_LSB +: SRC_W] == SRC_VCO && control_q[PRESCALE_LSB +: PRESCALE_W] == '0
      && $stable(control_q) && pin_rise[PIN_VCO] |=> PIXEL_CLOCK_EN)
    else $error("VCO feedback edge gave no pixel tick");
endmodule : pixel_clock_pll_phase_comparator

// file: rtl/pixel_prescaler.sv
`timescale 1ns/100ps
module pixel_prescaler
  import pll_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic [PRESCALE_W-1:0] ratio,
  output logic pulse
);
  logic [PRESCALE_W-1:0] cnt_q;
  logic pulse_q;

  // Field value n divides by n+1, so ratios one to eight
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (tick) begin
      if (cnt_q >= ratio) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= tick && (cnt_q >= ratio);
    end
  end

  assign pulse = pulse_q;

  a_prescale_bypass: assert property (@(posedge clk) disable iff (!arst_n)
    tick && ratio == '0 |=> pulse_q)
    else $error("Divide by one lost a pixel tick");
endmodule : pixel_prescaler

// file: rtl/pll_pkg.sv
// Behaviour
// - Control bits 1:0 choose the pixel clock source.
// - Control bits 4:2 set a prescaler dividing the pixel clock by one to eight.
// - Sources are the direct high-rate input, VCO feedback and the internal reference.
// - Sound runs from the reference or a sound clock pin, halved internally.
// - Two preloadable down counters, reference and VCO clocked, loaded from synthesizer moduli.
// - Synthesizer bit 6 forces correction high, bit 14 forces it low, both driven.
// - Synthesizer bit 7 holds the reference counter cleared.
// - Synthesizer bit 15 holds the VCO counter cleared.
// - Correction output floats unless a frequency correction is needed.
// - Correction drives high to raise VCO frequency, low to lower it.
// - Loop settles at reference frequency times (VCO modulus + 1) over (reference modulus + 1).
// - Locked operation uses the VCO feedback input as pixel clock source.
package pll_pkg;
  localparam int CLOCK_HZ = 40_000_000;
  localparam int REF_HZ = 32_000_000;
  localparam int ADDR_W = 8;
  localparam int SYNC_STAGES = 3;
  // Register indices; byte address is four times the index
  localparam logic [5:0] CONTROL_INDEX = 6'h0E;
  localparam logic [5:0] SYNTH_INDEX = 6'h0D;
  localparam logic [5:0] STATUS_INDEX = 6'h0F;
  localparam logic [ADDR_W-1:0] CONTROL_ADDR = {CONTROL_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] SYNTH_ADDR = {SYNTH_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] SYNTH_RESET = 16'h0000;
  // Control fields
  localparam int SRC_LSB = 0;
  localparam int SRC_W = 2;
  localparam int PRESCALE_LSB = 2;
  localparam int PRESCALE_W = 3;
  localparam int SOUND_SEL_BIT = 5;
  localparam logic [1:0] SRC_DIRECT = 2'h0;
  localparam logic [1:0] SRC_VCO = 2'h1;
  localparam logic [1:0] SRC_REF = 2'h2;
  // Synthesizer fields
  localparam int MOD_W = 6;
  localparam int RMOD_LSB = 0;
  localparam int FORCE_HIGH_BIT = 6;
  localparam int CLEAR_R_BIT = 7;
  localparam int VMOD_LSB = 8;
  localparam int FORCE_LOW_BIT = 14;
  localparam int CLEAR_V_BIT = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {DET_IDLE, DET_UP, DET_DOWN} detector_state_t;
endpackage : pll_pkg

// file: verification/tb_pixel_clock_pll_phase_comparator.sv
`timescale 1ns/100ps
module tb_pixel_clock_pll_phase_comparator;
  import pll_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic io = 1'b0;
  logic hf = 1'b0;
  logic snd = 1'b0;
  logic vco_d = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, vco, vco_inv, corr_o, corr_oe, pix_en, snd_en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int io_c = 0, hf_c = 0, sd_c = 0;
  int n_pix = 0, n_snd = 0, n_vco = 0, n_oe = 0;
  int err_total = 0;
  int check_count = 0;

  always #12.5 clock = ~clock;

  pixel_clock_pll_phase_comparator i_pixel_clock_pll_phase_comparator (
    .CLOCK(clock), .ARST_N(arst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .HIGH_FREQ_CLOCK_IN(hf),
    .VCO_FEEDBACK_CLOCK_IN(vco), .IO_CLOCK_INPUT(io), .SOUND_CLOCK_IN(snd),
    .VCO_FEEDBACK_INVERTED_OUT(vco_inv), .PHASE_CORRECTION_OUT_O(corr_o),
    .PHASE_CORRECTION_OUT_OE(corr_oe), .PIXEL_CLOCK_EN(pix_en), .SOUND_CLOCK_EN(snd_en)
  );

  vco_model i_vco_model (.clk(clock), .corr_o(corr_o), .corr_oe(corr_oe), .vco(vco));

  localparam int IO_PER = 8;
  localparam int HF_PER = 12;
  localparam int SND_PER = 16;
  // Slowest oscillator period: twice the model's longest half period
  localparam int VCO_SLOW_PER = 80;

  // Pins are slow enough for the three-flop sampling
  always @(posedge clock) begin
    io_c <= (io_c + 1) % IO_PER;
    hf_c <= (hf_c + 1) % HF_PER;
    sd_c <= (sd_c + 1) % SND_PER;
    io <= io_c < IO_PER / 2;
    hf <= hf_c < HF_PER / 2;
    snd <= sd_c < SND_PER / 2;
    vco_d <= vco;
    n_pix <= n_pix + int'(pix_en);
    n_snd <= n_snd + int'(snd_en);
    n_oe <= n_oe + int'(corr_oe);
    n_vco <= n_vco + int'(vco && !vco_d);
  end

  task automatic results();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic near(input int got, input int exp, input int tol);
    check_count++;
    if (got > exp + tol || got < exp - tol) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : near

  // Events expected in w cycles from a source of the given period, scaled by num over den
  function automatic int rate(input int w, input int period, input int num, input int den);
    return (w * num) / (period * den);
  endfunction : rate

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 200) begin
      err_total++;
      results();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 200) begin
      err_total++;
      results();
    end
  endtask : rd

  task automatic wrok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(32'(r), 32'(RESP_OKAY));
  endtask : wrok

  // Event counts over a window of w cycles: pixel, sound, vco rises, driven cycles
  task automatic window(input int w, output int p, output int s, output int v, output int o);
    int a0, a1, a2, a3;
    a0 = n_pix;
    a1 = n_snd;
    a2 = n_vco;
    a3 = n_oe;
    repeat (w) @(posedge clock);
    p = n_pix - a0;
    s = n_snd - a1;
    v = n_vco - a2;
    o = n_oe - a3;
  endtask : window

  initial begin
    logic [31:0] d, x;
    logic [1:0] r;
    int p, s, v, o, k, mx;
    void'($urandom(11));
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    chk(32'({corr_oe, corr_o}), 32'h0);
    rd(CONTROL_ADDR, d, r);
    chk(32'(d[7:0]), 32'(CONTROL_RESET));
    rd(SYNTH_ADDR, d, r);
    chk(32'(d[15:0]), 32'(SYNTH_RESET));
    wr(8'h40, 32'hFFFF, r);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(8'h40, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    for (k = 0; k < 6; k++) begin
      x = $urandom;
      wrok(CONTROL_ADDR, x);
      rd(CONTROL_ADDR, d, r);
      chk(32'(d[5:0]), 32'(x[5:0]));
      x = $urandom & 32'h3F3F;
      wrok(SYNTH_ADDR, x);
      rd(SYNTH_ADDR, d, r);
      chk(32'(d[15:0]), x);
    end
    wrok(SYNTH_ADDR, 32'h0);
    for (k = 0; k < 8; k++) begin
      wrok(CONTROL_ADDR, 32'(k * 4 + 2 + $urandom % 2));
      window(512, p, s, v, o);
      near(p, rate(512, IO_PER, 1, k + 1), 1);
      near(s, rate(512, IO_PER, 1, 2), 1);
    end
    wrok(CONTROL_ADDR, 32'h20);
    window(512, p, s, v, o);
    near(p, rate(512, HF_PER, 1, 1), 1);
    near(s, rate(512, SND_PER, 1, 2), 1);
    wrok(CONTROL_ADDR, 32'h01);
    window(512, p, s, v, o);
    near(p, v, 1);
    for (k = 0; k < 20; k++) begin
      repeat (1 + $urandom % 9) @(posedge clock);
      chk(32'(vco_inv), {31'h0, ~vco});
    end
    wrok(SYNTH_ADDR, 32'h0040);
    repeat (3) @(posedge clock);
    chk(32'({corr_oe, corr_o}), 32'h3);
    wrok(SYNTH_ADDR, 32'h4000);
    repeat (3) @(posedge clock);
    chk(32'({corr_oe, corr_o}), 32'h2);
    wrok(SYNTH_ADDR, 32'h4040);
    repeat (3) @(posedge clock);
    chk(32'({corr_oe, corr_o}), 32'h2);
    wrok(SYNTH_ADDR, 32'h8385);
    repeat (40) @(posedge clock);
    rd(STATUS_ADDR, d, r);
    chk(32'({d[17:12], d[9:4]}), 32'h0);
    wrok(SYNTH_ADDR, 32'h0385);
    repeat (40) @(posedge clock);
    rd(STATUS_ADDR, d, r);
    chk(32'(d[9:4]), 32'h0);
    wrok(SYNTH_ADDR, 32'h0305);
    mx = 0;
    for (k = 0; k < 16; k++) begin
      repeat (1 + $urandom % 7) @(posedge clock);
      rd(STATUS_ADDR, d, r);
      if (int'(d[9:4]) > mx) mx = int'(d[9:4]);
    end
    chk(32'(mx > 0 && mx <= 5), 32'h1);
    // Power-up recovery: drive the oscillator to its slowest rate first
    wrok(SYNTH_ADDR, 32'hC187);
    repeat (1600) @(posedge clock);
    window(800, p, s, v, o);
    near(v, rate(800, VCO_SLOW_PER, 1, 1), 1);
    wrok(SYNTH_ADDR, 32'hC183);
    wrok(SYNTH_ADDR, 32'h0103);
    // A first oscillator expiry may ask briefly for slow-down; the slow oscillator must then be driven up
    for (k = 0; k < 400 && !(corr_oe && corr_o); k++) @(posedge clock);
    chk(32'({corr_oe, corr_o}), 32'h3);
    if (k == 400) results();
    repeat (3000) @(posedge clock);
    window(2048, p, s, v, o);
    near(v, rate(2048, IO_PER, 2, 4), 6);
    chk(32'(o < 2048), 32'h1);
    wrok(SYNTH_ADDR, 32'h0101);
    repeat (3000) @(posedge clock);
    window(2048, p, s, v, o);
    near(v, rate(2048, IO_PER, 2, 2), 8);
    results();
  end
endmodule : tb_pixel_clock_pll_phase_comparator

// file: verification/vco_model.sv
`timescale 1ns/100ps
module vco_model #(
  parameter int MIN_HALF = 3,
  parameter int MAX_HALF = 40
) (
  input wire logic clk,
  input wire logic corr_o,
  input wire logic corr_oe,
  output logic vco
);
  int half_q = 20;
  int cnt_q = 0;
  initial vco = 1'b0;
  // Filter holds its voltage while the pin floats, so the rate only moves when driven
  always @(posedge clk) begin
    if (cnt_q + 1 >= half_q) begin
      cnt_q <= 0;
      vco <= ~vco;
      if (corr_oe && corr_o && half_q > MIN_HALF) begin
        half_q <= half_q - 1;
      end else if (corr_oe && !corr_o && half_q < MAX_HALF) begin
        half_q <= half_q + 1;
      end
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule : vco_model
